// File: design/stwp_prescaler.sv
// shared prescaler: counts input events, emits one tick per selected ratio
`timescale 1ns/100ps
`include "stwp_map.svh"

module stwp_prescaler
(
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	// count control
	input  wire logic                    event_in,
	input  wire logic                    clear,
	input  wire logic [`STWP_PRE_W-1:0]  ratio_mask,
	// result
	output logic                         tick_out
);
	import stwp_pkg::*;

	logic [`STWP_PRE_W-1:0] cnt_r;
	logic [`STWP_PRE_W-1:0] cnt_nxt;

	// count is internal only; nothing reads or loads it from outside
	always_comb
	begin
		tick_out = event_in && !clear &&
			((cnt_r & ratio_mask) == ratio_mask);
		cnt_nxt = cnt_r;
		if (clear)
			cnt_nxt = '0;
		else if (event_in)
			cnt_nxt = cnt_r + 8'h01;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

endmodule

// File: design/stwp_timer_top.sv
// 8-bit timer with prescaler shared with the watchdog, AHB-Lite registers
// How it works
// - One prescaler serves either the timer or the watchdog; the other runs undivided.
// - The prescaler count cannot be read or loaded through any register.
// - Option bits 3..0 hold owner and rate; code 111 divides by 256 or 128.
// - Owner bit clear gives the prescaler to the timer, set to the watchdog.
// - Any write to the timer count clears the prescaler while the timer owns it.
// - A timer count write leaves owner and rate untouched.
// - Watchdog clear resets the watchdog counter and, if it owns it, the prescaler.
// - Timer wrap from FF to 00 sets the overflow flag, interrupt control bit 2.
// - Clock source bit set makes the timer count pin edges, not cycles.
// - Edge select clear counts rising pin edges, set counts falling ones.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/100ps
`include "stwp_map.svh"

module stwp_timer_top
(
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	// ahb-lite slave
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic                 hready,
	input  wire logic [31:0]          hwdata,
	output logic [31:0]               hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	// timer and watchdog side
	input  wire logic                 timer_ext_clock_pin,
	input  wire logic                 watchdog_osc_tick,
	input  wire logic                 watchdog_clear_instr,
	output logic                      watchdog_tick,
	output logic                      watchdog_counter_clear,
	// interrupt
	output logic                      irq
);
	import stwp_pkg::*;

	// bus state
	stwp_bus_st_t           bus_st_r;
	stwp_bus_st_t           bus_st_nxt;
	logic [7:0]             idx_r;
	logic [7:0]             idx_nxt;
	logic                   wr_r;
	logic                   wr_nxt;
	logic                   adr_ok_r;
	logic                   adr_ok_nxt;
	logic [31:0]            hrdata_r;
	logic [31:0]            hrdata_nxt;
	logic                   hready_r;
	logic                   hready_nxt;

	// registers
	stwp_byte_t             timer_r;
	stwp_byte_t             timer_nxt;
	stwp_byte_t             intctl_r;
	stwp_byte_t             intctl_nxt;
	stwp_byte_t             option_r;
	stwp_byte_t             option_nxt;
	logic [`STWP_IRQ_W-1:0] irq_stat_r;
	logic [`STWP_IRQ_W-1:0] irq_stat_nxt;
	logic [`STWP_IRQ_W-1:0] irq_mask_r;
	logic [`STWP_IRQ_W-1:0] irq_mask_nxt;
	logic                   irq_r;
	logic                   irq_nxt;

	// timer and watchdog side
	logic                   pin_prev_r;
	logic                   wd_tick_r;
	logic                   wd_tick_nxt;
	logic                   wd_clr_r;
	logic                   wd_clr_nxt;

	// decode and datapath helpers
	logic                   take;
	logic                   wr_en;
	logic                   wr_timer;
	stwp_owner_t            owner;
	logic [2:0]             rate;
	logic                   rise;
	logic                   fall;
	logic                   timer_evt;
	logic                   pre_evt;
	logic                   pre_clr;
	logic [`STWP_PRE_W-1:0] pre_mask;
	logic                   pre_tick;
	logic                   timer_step;
	logic                   wd_step;
	logic                   overflow;
	logic [`STWP_IRQ_W-1:0] irq_evt;

	assign hrdata    = hrdata_r;
	assign hreadyout = hready_r;
	assign hresp     = 1'b0;
	assign irq       = irq_r;
	assign watchdog_tick          = wd_tick_r;
	assign watchdog_counter_clear = wd_clr_r;

	// owner and rate are only ever changed by an option write
	assign owner = option_r[`STWP_OPT_OWNER] ? STWP_OWNER_WDOG
		: STWP_OWNER_TIMER;
	assign rate  = option_r[`STWP_OPT_RATE_HI:`STWP_OPT_RATE_LO];

	// pin is synchronous to clk, so one stage of history is enough
	assign rise = timer_ext_clock_pin && !pin_prev_r;
	assign fall = !timer_ext_clock_pin && pin_prev_r;

	always_comb
	begin
		if (option_r[`STWP_OPT_CLKSRC])
			timer_evt = option_r[`STWP_OPT_EDGE] ? fall : rise;
		else
			timer_evt = 1'b1;
	end

	// address phase taken only while the bus is ready
	assign take  = hsel && htrans[1] && hready && (bus_st_r == STWP_BUS_IDLE);
	assign wr_en = (bus_st_r == STWP_BUS_DATA) && wr_r && adr_ok_r;
	assign wr_timer = wr_en && (idx_r == `STWP_IDX_TIMER);

	// timer ratio 2^(rate+1), watchdog ratio 2^rate, so watchdog is half
	always_comb
	begin
		if (owner == STWP_OWNER_TIMER)
			pre_mask = `STWP_MASK_ALL >> (4'd7 - {1'b0, rate});
		else
			pre_mask = `STWP_MASK_ALL >> (4'd8 - {1'b0, rate});
	end

	// exactly one user feeds the prescaler at a time
	always_comb
	begin
		if (owner == STWP_OWNER_TIMER)
		begin
			pre_evt    = timer_evt;
			pre_clr    = wr_timer;
			timer_step = pre_tick;
			wd_step    = watchdog_osc_tick;
		end
		else
		begin
			pre_evt    = watchdog_osc_tick;
			pre_clr    = watchdog_clear_instr;
			timer_step = timer_evt;
			wd_step    = pre_tick;
		end
	end

	stwp_prescaler u_prescaler
	(
		.clk        (clk),
		.rst_n      (rst_n),
		.event_in   (pre_evt),
		.clear      (pre_clr),
		.ratio_mask (pre_mask),
		.tick_out   (pre_tick)
	);

	// a write wins over a step in the same cycle
	assign overflow = timer_step && !wr_timer && (timer_r == 8'hFF);
	assign irq_evt  = {wd_step, overflow};

	// bus slave: one wait cycle so read data reflects a write just before
	always_comb
	begin
		bus_st_nxt = bus_st_r;
		idx_nxt    = idx_r;
		wr_nxt     = wr_r;
		adr_ok_nxt = adr_ok_r;
		hrdata_nxt = hrdata_r;
		hready_nxt = hready_r;
		case (bus_st_r)
			STWP_BUS_IDLE:
			begin
				if (take)
				begin
					idx_nxt    = haddr[`STWP_ADDR_W-1:2];
					wr_nxt     = hwrite;
					adr_ok_nxt = (haddr[31:`STWP_ADDR_W] == '0)
						&& (haddr[1:0] == 2'b00);
					hready_nxt = 1'b0;
					bus_st_nxt = STWP_BUS_DATA;
				end
			end
			STWP_BUS_DATA:
			begin
				hrdata_nxt = 32'h0000_0000;
				if (!wr_r && adr_ok_r)
				begin
					case (idx_r)
						`STWP_IDX_TIMER:    hrdata_nxt[7:0] = timer_r;
						`STWP_IDX_INTCTL:   hrdata_nxt[7:0] = intctl_r;
						`STWP_IDX_OPTION:   hrdata_nxt[7:0] = option_r;
						`STWP_IDX_IRQ_STAT:
							hrdata_nxt[`STWP_IRQ_W-1:0] = irq_stat_r;
						`STWP_IDX_IRQ_MASK:
							hrdata_nxt[`STWP_IRQ_W-1:0] = irq_mask_r;
						default:            hrdata_nxt = 32'h0000_0000;
					endcase
				end
				hready_nxt = 1'b1;
				bus_st_nxt = STWP_BUS_IDLE;
			end
			default:
			begin
				hready_nxt = 1'b1;
				bus_st_nxt = STWP_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			bus_st_r <= STWP_BUS_IDLE;
			idx_r    <= 8'h00;
			wr_r     <= 1'b0;
			adr_ok_r <= 1'b0;
			hrdata_r <= 32'h0000_0000;
			hready_r <= 1'b1;
		end
		else
		begin
			bus_st_r <= bus_st_nxt;
			idx_r    <= idx_nxt;
			wr_r     <= wr_nxt;
			adr_ok_r <= adr_ok_nxt;
			hrdata_r <= hrdata_nxt;
			hready_r <= hready_nxt;
		end
	end

	// register file and timer count
	always_comb
	begin
		timer_nxt    = timer_r;
		intctl_nxt   = intctl_r;
		option_nxt   = option_r;
		irq_stat_nxt = irq_stat_r;
		irq_mask_nxt = irq_mask_r;
		if (timer_step)
			timer_nxt = timer_r + 8'h01;
		if (wr_en)
		begin
			case (idx_r)
				// count write touches nothing in the option register
				`STWP_IDX_TIMER:    timer_nxt = hwdata[7:0];
				`STWP_IDX_INTCTL:   intctl_nxt = hwdata[7:0];
				`STWP_IDX_OPTION:   option_nxt = hwdata[7:0];
				`STWP_IDX_IRQ_STAT:
					irq_stat_nxt = irq_stat_r
						& ~hwdata[`STWP_IRQ_W-1:0];
				`STWP_IDX_IRQ_MASK:
					irq_mask_nxt = hwdata[`STWP_IRQ_W-1:0];
				default:            timer_nxt = timer_nxt;
			endcase
		end
		// hardware set beats a software clear in the same cycle
		if (overflow)
			intctl_nxt[`STWP_INTCTL_TOF] = 1'b1;
		irq_stat_nxt = irq_stat_nxt | irq_evt;
		irq_nxt      = |(irq_stat_nxt & irq_mask_nxt);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			timer_r    <= `STWP_TIMER_RST;
			intctl_r   <= `STWP_INTCTL_RST;
			option_r   <= `STWP_OPTION_RST;
			irq_stat_r <= `STWP_IRQ_RST;
			irq_mask_r <= `STWP_IRQ_RST;
			irq_r      <= 1'b0;
		end
		else
		begin
			timer_r    <= timer_nxt;
			intctl_r   <= intctl_nxt;
			option_r   <= option_nxt;
			irq_stat_r <= irq_stat_nxt;
			irq_mask_r <= irq_mask_nxt;
			irq_r      <= irq_nxt;
		end
	end

	// watchdog side: tick and counter clear leave as registered pulses
	always_comb
	begin
		wd_tick_nxt = wd_step;
		wd_clr_nxt  = watchdog_clear_instr;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pin_prev_r <= 1'b0;
			wd_tick_r  <= 1'b0;
			wd_clr_r   <= 1'b0;
		end
		else
		begin
			pin_prev_r <= timer_ext_clock_pin;
			wd_tick_r  <= wd_tick_nxt;
			wd_clr_r   <= wd_clr_nxt;
		end
	end

endmodule

// File: dv/stwp_timer_top_properties.sv
// port checks for the shared timer prescaler block
`timescale 1ns/100ps
module stwp_timer_props
(
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// ahb-lite slave
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// watchdog side and interrupt
	input wire logic        watchdog_osc_tick,
	input wire logic        watchdog_clear_instr,
	input wire logic        watchdog_tick,
	input wire logic        watchdog_counter_clear,
	input wire logic        irq
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic acc;
	assign acc = hsel & htrans[1] & hready & hreadyout;
	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay) else $error("hresp not okay");
	property p_ack; acc |=> !hreadyout ##1 hreadyout; endproperty
	a_ack: assert property (p_ack) else $error("bad wait state");
	property p_rdy_src; $fell(hreadyout) |-> $past(acc); endproperty
	a_rdy_src: assert property (p_rdy_src) else $error("stray wait");
	property p_one_wait; !hreadyout |=> hreadyout; endproperty
	a_one_wait: assert property (p_one_wait) else $error("long wait");
	property p_rd_hold; hreadyout && $past(hreadyout) |-> $stable(hrdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("hrdata moved");
	property p_wclr; watchdog_clear_instr |=> watchdog_counter_clear;
	endproperty
	a_wclr: assert property (p_wclr) else $error("clear lost");
	property p_wclr_src;
		watchdog_counter_clear |-> $past(watchdog_clear_instr);
	endproperty
	a_wclr_src: assert property (p_wclr_src) else $error("stray clear");
	property p_wtick_src; watchdog_tick |-> $past(watchdog_osc_tick);
	endproperty
	a_wtick_src: assert property (p_wtick_src) else $error("stray tick");
	c_read: cover property (acc && !hwrite);
	c_wtick: cover property (watchdog_tick);
	c_irq: cover property ($rose(irq));
endmodule

bind stwp_timer_top stwp_timer_props stwp_timer_props_i
(
	.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
	.hreadyout, .hresp, .watchdog_osc_tick, .watchdog_clear_instr,
	.watchdog_tick, .watchdog_counter_clear, .irq
);

// File: dv/stwp_timer_top_tb.sv
// self-checking bench for the shared timer prescaler block
`timescale 1ns/100ps
`include "stwp_map.svh"
module stwp_timer_top_tb;
	logic        clk = 0;
	logic        rst_n = 0;
	logic [31:0] haddr = '0;
	logic [1:0]  htrans = '0;
	logic        hwrite = 0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, watchdog_tick, watchdog_counter_clear, irq;
	logic        timer_ext_clock_pin = 0;
	logic        watchdog_osc_tick = 0;
	logic        watchdog_clear_instr = 0;
	logic [7:0]  v, v0;
	int          err_total = 0, n_checks = 0, cyc = 0, tsamp, wt_n = 0;
	always #2 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	always @(posedge clk) if (watchdog_tick === 1'b1) wt_n <= wt_n + 1;
	stwp_timer_top stwp_timer_top_i
	(
		.clk, .rst_n, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
		.timer_ext_clock_pin, .watchdog_osc_tick, .watchdog_clear_instr,
		.watchdog_tick, .watchdog_counter_clear, .irq
	);
	task automatic xfer(logic [7:0] i, logic w, logic [7:0] d);
		htrans <= 2'h2;
		haddr <= {22'h0, i, 2'b00};
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hreadyout !== 1'b1);
		v = hrdata[7:0];
		tsamp = cyc;
	endtask
	task automatic chk(string s, logic [7:0] e, logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", s, e, g);
		end
	endtask
	// two reads exactly 3*k cycles apart: divider k gives 3 steps
	task automatic tdiff(int k);
		xfer(`STWP_IDX_TIMER, 0, 8'h00);
		v0 = v;
		while (cyc != tsamp + 3 * k - 3) @(posedge clk);
		xfer(`STWP_IDX_TIMER, 0, 8'h00);
		chk("timer steps", 8'h03, 8'(v - v0));
	endtask
	task automatic pclr;
		watchdog_clear_instr <= 1;
		@(posedge clk);
		watchdog_clear_instr <= 0;
	endtask
	// n oscillator ticks, optional clear halfway, e ticks expected
	task automatic wdiv(int n, int e, bit mid);
		int w0;
		pclr();
		repeat (2) @(posedge clk);
		w0 = wt_n;
		watchdog_osc_tick <= 1;
		repeat (n / 2) @(posedge clk);
		if (mid) pclr();
		else @(posedge clk);
		repeat (n / 2 - 1) @(posedge clk);
		watchdog_osc_tick <= 0;
		repeat (3) @(posedge clk);
		chk("wdog ticks", 8'(e), 8'(wt_n - w0));
	endtask
	task final_report;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		#80000;
		err_total++;
		final_report();
	end
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		xfer(`STWP_IDX_OPTION, 0, 8'h00);
		chk("option rst", 8'hFF, v);
		xfer(`STWP_IDX_TIMER, 0, 8'h00);
		chk("timer rst", 8'h00, v);
		xfer(8'h02, 0, 8'h00);
		chk("unmapped", 8'h00, v);
		for (int r = 0; r < 8; r++)
		begin
			xfer(`STWP_IDX_OPTION, 1, 8'(r));
			tdiff(2 << r);
			xfer(`STWP_IDX_OPTION, 1, 8'(8 + r));
			wdiv(4 << r, 4, 0);
		end
		tdiff(1);
		wdiv(200, 0, 1);
		xfer(`STWP_IDX_OPTION, 1, 8'h00);
		wdiv(10, 10, 0);
		// timer write restarts the 1:256 divider
		xfer(`STWP_IDX_OPTION, 1, 8'h07);
		xfer(`STWP_IDX_TIMER, 1, 8'h10);
		repeat (200) @(posedge clk);
		xfer(`STWP_IDX_TIMER, 1, 8'h10);
		repeat (200) @(posedge clk);
		xfer(`STWP_IDX_TIMER, 0, 8'h00);
		chk("timer held", 8'h10, v);
		xfer(`STWP_IDX_OPTION, 0, 8'h00);
		chk("option kept", 8'h07, v);
		// pin counting on rising, then falling edges
		for (int e = 0; e < 2; e++)
		begin
			xfer(`STWP_IDX_OPTION, 1, e ? 8'h38 : 8'h28);
			timer_ext_clock_pin <= 0;
			repeat (3) @(posedge clk);
			xfer(`STWP_IDX_TIMER, 1, 8'h00);
			repeat (5)
			begin
				timer_ext_clock_pin <= ~timer_ext_clock_pin;
				repeat (2) @(posedge clk);
			end
			xfer(`STWP_IDX_TIMER, 0, 8'h00);
			chk("pin count", e ? 8'h02 : 8'h03, v);
		end
		// overflow flag, mask and write-one-to-clear
		xfer(`STWP_IDX_OPTION, 1, 8'h08);
		xfer(`STWP_IDX_INTCTL, 1, 8'h00);
		xfer(`STWP_IDX_IRQ_STAT, 1, 8'h03);
		xfer(`STWP_IDX_TIMER, 1, 8'hFC);
		repeat (10) @(posedge clk);
		xfer(`STWP_IDX_INTCTL, 0, 8'h00);
		chk("intctl", 8'h04, v);
		xfer(`STWP_IDX_IRQ_STAT, 0, 8'h00);
		chk("status", 8'h01, v);
		chk("irq masked", 8'h00, {7'h0, irq});
		xfer(`STWP_IDX_IRQ_MASK, 1, 8'h01);
		repeat (2) @(posedge clk);
		chk("irq on", 8'h01, {7'h0, irq});
		xfer(`STWP_IDX_IRQ_STAT, 1, 8'h01);
		repeat (2) @(posedge clk);
		chk("irq off", 8'h00, {7'h0, irq});
		// hand the prescaler to the watchdog, final ratio 1:1
		xfer(`STWP_IDX_OPTION, 1, 8'h01);
		xfer(`STWP_IDX_TIMER, 1, 8'h00);
		xfer(`STWP_IDX_OPTION, 1, 8'h09);
		pclr();
		xfer(`STWP_IDX_OPTION, 1, 8'h08);
		wdiv(6, 6, 0);
		// and back to the timer at 1:8
		pclr();
		xfer(`STWP_IDX_OPTION, 1, 8'h02);
		tdiff(8);
		final_report();
	end
endmodule

// File: inc/stwp_map.svh
// register offsets, field positions and reset values of the timer block
`ifndef STWP_MAP_SVH
`define STWP_MAP_SVH

// register indices; the byte address is four times the index
`define STWP_ADDR_W        10
`define STWP_IDX_TIMER     8'h01
`define STWP_IDX_INTCTL    8'h0B
`define STWP_IDX_OPTION    8'h81
`define STWP_IDX_IRQ_STAT  8'h90
`define STWP_IDX_IRQ_MASK  8'h91

// option register fields
`define STWP_OPT_CLKSRC    5
`define STWP_OPT_EDGE      4
`define STWP_OPT_OWNER     3
`define STWP_OPT_RATE_HI   2
`define STWP_OPT_RATE_LO   0

// interrupt control fields
`define STWP_INTCTL_TOF    2

// sticky status / mask fields
`define STWP_IRQ_W         2
`define STWP_IRQ_TOF       0
`define STWP_IRQ_WDT       1

// reset values
`define STWP_TIMER_RST     8'h00
`define STWP_INTCTL_RST    8'h00
`define STWP_OPTION_RST    8'hFF
`define STWP_IRQ_RST       2'h0

// prescaler
`define STWP_PRE_W         8
`define STWP_MASK_ALL      8'hFF

`endif

// File: inc/stwp_pkg.sv
// types shared by the timer and prescaler design
package stwp_pkg;

	typedef enum logic
	{
		STWP_OWNER_TIMER,
		STWP_OWNER_WDOG
	} stwp_owner_t;

	typedef enum
	{
		STWP_BUS_IDLE,
		STWP_BUS_DATA
	} stwp_bus_st_t;

	typedef logic [7:0] stwp_byte_t;

endpackage
